// ### verilog/smx_defines.svh
// Constants for the store and multiply execution slice.
`ifndef SMX_DEFINES_SVH
`define SMX_DEFINES_SVH
`define SMX_OP_STORE_CPU 8'he5
`define SMX_OP_STORE_RETURN_ADDRESS_REG 8'heb
`define SMX_OP_STORE_XPTR 8'hed
`define SMX_OP_LOAD_STORE 8'h87
`define SMX_OP_MPY_ACC 7'h2a
`define SMX_OP_MPY_T 7'h2c
`define SMX_OP_MPYK8 7'h0f
`define SMX_OP_MPYK16 8'h79
`define SMX_OP_MPYM 8'hd3
`define SMX_OP_MPYM_COEF 8'hd1
`define SMX_SHIFT_MAX 7'sd31
`define SMX_SHIFT_MIN (-7'sd32)
`define SMX_RETURN_ADDRESS_REG_CYCLES 3'd5
`define SMX_XPTR_ZERO_BITS 9
`endif

// ### verilog/smx_pkg.sv
// Types shared by the store and multiply execution slice.
package smx_pkg;
  // Selected source register for a CPU register store.
  typedef enum logic [4:0] {
    SMX_REG_NONE, SMX_REG_BLOCK_SIZE_0_3, SMX_REG_BLOCK_SIZE_4_7, SMX_REG_COEF_BLOCK_SIZE,
    SMX_REG_BUF_START_0_1, SMX_REG_BUF_START_2_3, SMX_REG_BUF_START_4_5,
    SMX_REG_BUF_START_6_7, SMX_REG_COEF_BUF_START, SMX_REG_LOOP_COUNT_0,
    SMX_REG_LOOP_COUNT_1, SMX_REG_COEF_POINTER, SMX_REG_SINGLE_REPEAT,
    SMX_REG_DATA_PAGE, SMX_REG_DATA_PAGE_HIGH, SMX_REG_PERIPHERAL_PAGE,
    SMX_REG_DATA_STACK_PTR, SMX_REG_SYSTEM_STACK_PTR, SMX_REG_TRANSITION_0,
    SMX_REG_TRANSITION_1
  } smx_reg_sel_t;

  typedef struct packed {
    logic fractional_mode_bit;
    logic multiply_saturation_bit;
    logic rounding_mode_bit;
    logic wide_overflow_mode;
    logic data_saturation_bit;
    logic sign_extension_mode;
    logic legacy_compat_mode;
    logic store_saturate_bit;
  } smx_mode_t;

  typedef struct packed {
    logic valid;
    logic dbl;
    logic [15:0] hi;
    logic [15:0] lo;
  } smx_store_t;
endpackage

// ### verilog/smx_mac.sv
// Multiplier stage: 17 by 17 product with fractional shift, rounding and saturation.
`timescale 1ns/1ps
`default_nettype none
module smx_mac
  import smx_pkg::*;
(
  input wire logic [16:0] op_a,
  input wire logic [16:0] op_b,
  input wire smx_mode_t mode,
  input wire logic round_en,
  output logic [39:0] result,
  output logic overflow
);
  logic signed [33:0] prod;
  logic signed [33:0] prod_f;
  logic signed [39:0] wide;
  logic signed [39:0] rnd;
  logic mul_ovf;
  logic acc_ovf;
  always_comb begin
    prod = $signed(op_a) * $signed(op_b);
    prod_f = mode.fractional_mode_bit ? (prod <<< 1) : prod;
    mul_ovf = mode.multiply_saturation_bit && mode.fractional_mode_bit &&
              (prod_f[31:0] == 32'h80000000) && (prod_f[33:32] == 2'b00);
    // sign extend to 40 bits
    // The whole signed product is kept so that a positive product above bit 31 can overflow.
    wide = mul_ovf ? 40'sh007fffffff : {{6{prod_f[33]}}, prod_f};
    rnd = wide;
    if (round_en) begin
      rnd = wide + 40'sh0000008000;
      if (!mode.rounding_mode_bit || rnd[15:0] != 16'h0000) begin
        rnd[15:0] = 16'h0000;
      end else begin
        rnd[16:0] = 17'h00000;
      end
    end
    acc_ovf = mode.wide_overflow_mode ? 1'b0 : (rnd[39:31] != {9{rnd[31]}});
    overflow = acc_ovf;
    if (acc_ovf && mode.data_saturation_bit) begin
      result = rnd[39] ? 40'hff80000000 : 40'h007fffffff;
    end else begin
      result = rnd;
    end
  end
endmodule
`default_nettype wire

// ### verilog/smx_exec.sv
// Decode and execute for CPU register stores, load with store, and single multiply.
//
// Overview of operation
// - Store family 0xe5 selects block size registers by codes 1001/1010/1011 10xx.
// - Codes 0010-0101 10xx select buffer starts; 0110 10xx the coefficient start.
// - Pointer codes 10xx map to coefficient, page, stack and peripheral registers.
// - Codes x000..x100 11xx select loop counts, single repeat, transition registers.
// - Opcode 0xeb with xxxx 01xx stores return address and context as double word.
// - Extended store XSSS 0101 writes a 23-bit pointer to a 32-bit double word.
// - Extended store zero-fills top 9 bits; high 7 bits first word, low 16 next.
// - Store half shifts accumulator by temp count, clamped -32..31, stores 31-16.
// - Compatibility mode uses 6 count bits; -32..-17 reduced modulo 16.
// - Store saturate set with sign mode clear forces saturate and unsigned store.
// - Accumulator multiply uses bits 32-16 of both, result to second accumulator.
// - Non-accumulator multiply operands extend to 17 bits.
// - Fractional mode shifts the product left by one.
// - The 34-bit product is sign extended to 40 bits.
// - Rounding by rounding mode only with the rounding keyword.
// - Multiply overflow detection follows the multiply saturation bit.
// - Accumulator overflow follows the width mode and sets the overflow flag, except for the 8-bit constant multiply.
// - Overflowed result saturates according to the data saturation bit.
// - Return store: context and top 8 address bits high, low 16 bits low.
// - Return store flushes the pipeline and takes five cycles.
`timescale 1ns/1ps
`default_nettype none
`include "smx_defines.svh"
module smx_exec
  import smx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire smx_mode_t mode,
  input wire logic [15:0] cpu_reg_value,
  input wire logic [23:0] return_address_reg,
  input wire logic [7:0] flow_context_flags,
  input wire logic [22:0] extended_pointer_source,
  input wire logic [15:0] xmem_data,
  input wire logic [15:0] shift_count_temp,
  input wire logic [15:0] temp_reg,
  input wire logic [15:0] smem_data,
  input wire logic [15:0] cmem_data,
  input wire logic [39:0] source_accumulator,
  input wire logic [39:0] destination_accumulator,
  output smx_reg_sel_t reg_sel_reg,
  output smx_store_t store_reg,
  output logic [39:0] acc_wr_data_reg,
  output logic acc_wr_en_reg,
  output logic accumulator_overflow_flag_reg,
  output logic flush_reg,
  output logic busy_reg
);
  // ****************************************************************
  // Decode
  // ****************************************************************
  // masked compares
  function automatic logic match(input logic [7:0] v, input logic [7:0] pat,
                                 input logic [7:0] care);
    match = ((v ^ pat) & care) == 8'h00;
  endfunction

  logic [7:0] b0;
  logic [7:0] blast;
  smx_reg_sel_t sel_next;
  always_comb begin
    b0 = instr[31:24];
    blast = instr[7:0];
    sel_next = SMX_REG_NONE;
    if (b0 == `SMX_OP_STORE_CPU && match(blast, 8'h08, 8'h0c)) begin
      unique case (blast[7:4])
        4'h9: sel_next = SMX_REG_BLOCK_SIZE_0_3;
        4'ha: sel_next = SMX_REG_BLOCK_SIZE_4_7;
        4'hb: sel_next = SMX_REG_COEF_BLOCK_SIZE;
        4'h2: sel_next = SMX_REG_BUF_START_0_1;
        4'h3: sel_next = SMX_REG_BUF_START_2_3;
        4'h4: sel_next = SMX_REG_BUF_START_4_5;
        4'h5: sel_next = SMX_REG_BUF_START_6_7;
        4'h6: sel_next = SMX_REG_COEF_BUF_START;
        4'h1: sel_next = SMX_REG_COEF_POINTER;
        4'h0: sel_next = SMX_REG_DATA_PAGE;
        4'hc: sel_next = SMX_REG_DATA_PAGE_HIGH;
        4'hf: sel_next = SMX_REG_PERIPHERAL_PAGE;
        4'h7: sel_next = SMX_REG_DATA_STACK_PTR;
        4'h8: sel_next = SMX_REG_SYSTEM_STACK_PTR;
        default: sel_next = SMX_REG_NONE;
      endcase
    end else if (b0 == `SMX_OP_STORE_CPU && match(blast, 8'h0c, 8'h0c)) begin
      unique case (blast[6:4])
        3'h1: sel_next = SMX_REG_LOOP_COUNT_0;
        3'h2: sel_next = SMX_REG_LOOP_COUNT_1;
        3'h0: sel_next = SMX_REG_SINGLE_REPEAT;
        3'h3: sel_next = SMX_REG_TRANSITION_0;
        3'h4: sel_next = SMX_REG_TRANSITION_1;
        default: sel_next = SMX_REG_NONE;
      endcase
    end
  end

  logic is_return_address_reg;
  logic is_xptr;
  logic is_ldst;
  logic is_mpy_acc;
  logic is_mpy_t;
  logic is_mpyk8;
  logic is_mpyk16;
  logic is_mpym;
  logic is_mpym_coef;
  always_comb begin
    is_return_address_reg = b0 == `SMX_OP_STORE_RETURN_ADDRESS_REG && match(blast, 8'h04, 8'h0c);
    is_xptr = b0 == `SMX_OP_STORE_XPTR && blast[3:0] == 4'h5;
    is_ldst = b0 == `SMX_OP_LOAD_STORE && instr[7:5] == 3'b110;
    is_mpy_acc = instr[31:25] == `SMX_OP_MPY_ACC && instr[19:17] == 3'b011;
    is_mpy_t = instr[31:25] == `SMX_OP_MPY_T && instr[17] == 1'b0;
    is_mpyk8 = instr[31:25] == `SMX_OP_MPYK8 && instr[9] == 1'b0;
    is_mpyk16 = b0 == `SMX_OP_MPYK16 && instr[1] == 1'b0;
    is_mpym = b0 == `SMX_OP_MPYM && instr[3:2] == 2'b00;
    is_mpym_coef = b0 == `SMX_OP_MPYM_COEF && instr[3:2] == 2'b00;
  end

  // ****************************************************************
  // Store data path
  // ****************************************************************
  logic signed [6:0] cnt;
  logic signed [6:0] cnt_raw;
  logic signed [39:0] shifted;
  logic [15:0] st_hi;
  logic force_sat;
  always_comb begin
    if (mode.legacy_compat_mode) begin
      cnt_raw = {shift_count_temp[5], shift_count_temp[5:0]};
      cnt = (cnt_raw < -7'sd16) ? cnt_raw + 7'sd16 : cnt_raw;
    end else begin
      if ($signed(shift_count_temp) > 16'sd31) begin
        cnt = `SMX_SHIFT_MAX;
      end else if ($signed(shift_count_temp) < -16'sd32) begin
        cnt = `SMX_SHIFT_MIN;
      end else begin
        cnt = shift_count_temp[6:0];
      end
      cnt_raw = cnt;
    end
    // Separate branches keep the right shift arithmetic; a mixed conditional would not be.
    if (cnt[6] && mode.sign_extension_mode) begin
      shifted = $signed(source_accumulator) >>> (-cnt);
    end else if (cnt[6]) begin
      shifted = source_accumulator >> (-cnt);
    end else begin
      shifted = source_accumulator << cnt;
    end
    force_sat = mode.store_saturate_bit && !mode.sign_extension_mode;
    st_hi = shifted[31:16];
    if (force_sat && shifted[39:32] != 8'h00) begin
      st_hi = 16'hffff;
    end
  end

  logic [2:0] return_address_reg_cnt_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      return_address_reg_cnt_reg <= 3'd0;
      busy_reg <= 1'b0;
      flush_reg <= 1'b0;
    end else begin
      flush_reg <= instr_valid && !busy_reg && is_return_address_reg;
      if (instr_valid && !busy_reg && is_return_address_reg) begin
        return_address_reg_cnt_reg <= `SMX_RETURN_ADDRESS_REG_CYCLES - 3'd1;
        busy_reg <= 1'b1;
      end else if (return_address_reg_cnt_reg != 3'd0) begin
        return_address_reg_cnt_reg <= return_address_reg_cnt_reg - 3'd1;
        busy_reg <= return_address_reg_cnt_reg != 3'd1;
      end
    end
  end

  logic take;
  assign take = instr_valid && !busy_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      store_reg <= '0;
      reg_sel_reg <= SMX_REG_NONE;
    end else begin
      store_reg <= '0;
      reg_sel_reg <= take ? sel_next : SMX_REG_NONE;
      if (take && sel_next != SMX_REG_NONE) begin
        store_reg <= '{valid: 1'b1, dbl: 1'b0, hi: 16'h0000, lo: cpu_reg_value};
      end else if (take && is_return_address_reg) begin
        store_reg <= '{valid: 1'b1, dbl: 1'b1,
                       hi: {flow_context_flags, return_address_reg[23:16]},
                       lo: return_address_reg[15:0]};
      end else if (take && is_xptr) begin
        store_reg <= '{valid: 1'b1, dbl: 1'b1,
                       hi: {{`SMX_XPTR_ZERO_BITS{1'b0}}, extended_pointer_source[22:16]},
                       lo: extended_pointer_source[15:0]};
      end else if (take && is_ldst) begin
        store_reg <= '{valid: 1'b1, dbl: 1'b0, hi: 16'h0000, lo: st_hi};
      end
    end
  end

  // ****************************************************************
  // Multiply and load data path
  // ****************************************************************
  logic [16:0] op_a;
  logic [16:0] op_b;
  logic round_en;
  logic [39:0] mac_result;
  logic mac_ovf;
  logic [39:0] load_val;
  always_comb begin
    op_a = source_accumulator[32:16];
    op_b = 17'h00000;
    round_en = instr[0];
    if (is_mpy_acc) begin
      op_b = destination_accumulator[32:16];
    end else if (is_mpy_t) begin
      op_b = {temp_reg[15], temp_reg};
    end else if (is_mpyk8) begin
      op_b = {{9{instr[23]}}, instr[23:16]};
    end else if (is_mpyk16) begin
      op_b = {instr[23], instr[23:8]};
    end else if (is_mpym) begin
      op_b = {smem_data[15], smem_data};
    end else if (is_mpym_coef) begin
      op_a = {smem_data[15], smem_data};
      op_b = {cmem_data[15], cmem_data};
    end
    if (mode.sign_extension_mode) begin
      load_val = {{8{xmem_data[15]}}, xmem_data, 16'h0000};
    end else begin
      load_val = {8'h00, xmem_data, 16'h0000};
    end
  end

  smx_mac u_mac (
    .op_a(op_a),
    .op_b(op_b),
    .mode(mode),
    .round_en(round_en),
    .result(mac_result),
    .overflow(mac_ovf)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_wr_en_reg <= 1'b0;
      acc_wr_data_reg <= 40'h0000000000;
      accumulator_overflow_flag_reg <= 1'b0;
    end else begin
      acc_wr_en_reg <= 1'b0;
      accumulator_overflow_flag_reg <= 1'b0;
      if (take && is_ldst) begin
        acc_wr_en_reg <= 1'b1;
        acc_wr_data_reg <= load_val;
      end else if (take && (is_mpy_acc || is_mpy_t || is_mpyk8 || is_mpyk16 || is_mpym ||
                            is_mpym_coef)) begin
        acc_wr_en_reg <= 1'b1;
        acc_wr_data_reg <= mac_result;
        accumulator_overflow_flag_reg <= mac_ovf && !is_mpyk8;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/smx_exec_sva.sv
// Port checker for the store and multiply slice.
`timescale 1ns/1ps
`default_nettype none
module smx_exec_sva
  import smx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic [22:0] extended_pointer_source,
  input wire logic [23:0] return_address_reg,
  input wire logic [7:0] flow_context_flags,
  input wire logic [15:0] cpu_reg_value,
  input wire smx_reg_sel_t reg_sel_reg,
  input wire smx_store_t store_reg,
  input wire logic acc_wr_en_reg,
  input wire logic accumulator_overflow_flag_reg,
  input wire logic flush_reg,
  input wire logic busy_reg
);
  // ****
  // Operand copies
  // ****
  // Copies taken at the accepting edge, so the answer is judged on what was offered then.
  logic take;
  logic [15:0] cpu_q;
  logic [23:0] ra_q;
  logic [7:0] ctx_q;
  logic [22:0] xp_q;
  assign take = instr_valid && !busy_reg;
  always_ff @(posedge clk) begin
    cpu_q <= cpu_reg_value;
    ra_q <= return_address_reg;
    ctx_q <= flow_context_flags;
    xp_q <= extended_pointer_source;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_return_address_reg_busy_len: assert property (
    take && instr[31:24] == 8'heb && instr[3:2] == 2'b01 |=> busy_reg [*4] ##1 !busy_reg)
    else $error("busy length wrong");
  chk_return_address_reg_flush_pulse: assert property (
    take && instr[31:24] == 8'heb && instr[3:2] == 2'b01 |=> flush_reg ##1 !flush_reg)
    else $error("flush pulse wrong");
  chk_return_address_reg_words: assert property (
    take && instr[31:24] == 8'heb && instr[3:2] == 2'b01 |=> store_reg.valid && store_reg.dbl
    && store_reg.hi == {ctx_q, ra_q[23:16]} && store_reg.lo == ra_q[15:0])
    else $error("return store words wrong");
  chk_xptr_zero_fill: assert property (
    take && instr[31:24] == 8'hed && instr[3:0] == 4'h5 |=> store_reg.valid && store_reg.dbl
    && store_reg.hi == {9'h000, xp_q[22:16]} && store_reg.lo == xp_q[15:0])
    else $error("extended store words wrong");
  chk_block_size_sel: assert property (
    take && instr[31:24] == 8'he5 && instr[7:2] == 6'b100110
    |=> reg_sel_reg == SMX_REG_BLOCK_SIZE_0_3 && store_reg.valid && store_reg.lo == cpu_q)
    else $error("block size store wrong");
  chk_busy_refuses: assert property (
    $past(busy_reg) |-> !acc_wr_en_reg && !flush_reg && !store_reg.valid)
    else $error("request taken while busy");
  chk_ovf_with_write: assert property (
    accumulator_overflow_flag_reg |-> acc_wr_en_reg)
    else $error("overflow flag without write");
  chk_unknown_quiet: assert property (
    take && instr[31:24] == 8'h00 |=> !store_reg.valid && !acc_wr_en_reg)
    else $error("unknown opcode acted");
  chk_ldst_both: assert property (
    take && instr[31:24] == 8'h87 && instr[7:5] == 3'b110
    |=> acc_wr_en_reg && store_reg.valid && !store_reg.dbl)
    else $error("load with store incomplete");
  chk_mpy_acc_write: assert property (
    take && instr[31:25] == 7'h2a && instr[19:17] == 3'b011
    |=> acc_wr_en_reg && !store_reg.valid)
    else $error("accumulator multiply did not write");
endmodule
`default_nettype wire

// ### verif/smx_mem_model.sv
// Data memory model that receives the slice's store words.
`timescale 1ns/1ps
`default_nettype none
module smx_mem_model
  import smx_pkg::*;
(
  input wire logic clk,
  input wire smx_store_t store_reg,
  input wire logic [3:0] wr_addr,
  output logic [15:0] word_even,
  output logic [15:0] word_odd
);
  // ****
  // Storage
  // ****
  logic [15:0] mem [16];
  assign word_even = mem[wr_addr];
  assign word_odd = mem[wr_addr + 4'h1];
  always_ff @(posedge clk) begin
    if (store_reg.valid && store_reg.dbl) begin
      mem[wr_addr] <= store_reg.hi;
      mem[wr_addr + 4'h1] <= store_reg.lo;
    end else if (store_reg.valid) begin
      mem[wr_addr] <= store_reg.lo;
    end
  end
endmodule
`default_nettype wire

// ### verif/smx_exec_tb.sv
// Self-checking bench for the store and multiply slice.
`timescale 1ns/1ps
`default_nettype none
module smx_exec_tb
  import smx_pkg::*;
;
  logic clk, rst, instr_valid, acc_wr_en_reg, accumulator_overflow_flag_reg, flush_reg, busy_reg;
  logic [31:0] instr;
  smx_mode_t mode;
  logic [15:0] cpu_reg_value, xmem_data, shift_count_temp, temp_reg, smem_data, cmem_data;
  logic [23:0] return_address_reg;
  logic [7:0] flow_context_flags;
  logic [22:0] extended_pointer_source;
  logic [39:0] source_accumulator, destination_accumulator, acc_wr_data_reg;
  smx_reg_sel_t reg_sel_reg;
  smx_store_t store_reg;
  logic [3:0] wr_addr;
  logic [15:0] word_even, word_odd;
  int n_mismatch, tests_run, cyc;
  smx_exec dut_u (.clk, .rst, .instr_valid, .instr, .mode, .cpu_reg_value,
    .return_address_reg, .flow_context_flags, .extended_pointer_source, .xmem_data,
    .shift_count_temp, .temp_reg, .smem_data, .cmem_data, .source_accumulator,
    .destination_accumulator, .reg_sel_reg, .store_reg, .acc_wr_data_reg, .acc_wr_en_reg,
    .accumulator_overflow_flag_reg, .flush_reg, .busy_reg);
  smx_mem_model mem_u (.clk, .store_reg, .wr_addr, .word_even, .word_odd);
  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Outputs are sampled 1 ns after the taking edge, once its updates have landed.
  task automatic issue(input logic [31:0] op);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= op;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regsel;
    logic [7:0] code [19] = '{8'h98, 8'hab, 8'h6a, 8'h19, 8'hfb, 8'h9c, 8'h4f, 8'h0d, 8'h7a,
      8'hc9, 8'h29, 8'hae, 8'hb8, 8'h39, 8'h4a, 8'h5b, 8'h08, 8'h88, 8'hbc};
    smx_reg_sel_t exp [19] = '{SMX_REG_BLOCK_SIZE_0_3, SMX_REG_BLOCK_SIZE_4_7,
      SMX_REG_COEF_BUF_START, SMX_REG_COEF_POINTER, SMX_REG_PERIPHERAL_PAGE,
      SMX_REG_LOOP_COUNT_0, SMX_REG_TRANSITION_1, SMX_REG_SINGLE_REPEAT, SMX_REG_DATA_STACK_PTR,
      SMX_REG_DATA_PAGE_HIGH, SMX_REG_BUF_START_0_1, SMX_REG_LOOP_COUNT_1,
      SMX_REG_COEF_BLOCK_SIZE, SMX_REG_BUF_START_2_3, SMX_REG_BUF_START_4_5,
      SMX_REG_BUF_START_6_7, SMX_REG_DATA_PAGE, SMX_REG_SYSTEM_STACK_PTR, SMX_REG_TRANSITION_0};
    for (int i = 0; i < 19; i++) begin
      cpu_reg_value <= 16'h1000 + 16'(i);
      issue({8'he5, 8'(i * 37), 8'h5a, code[i]});
      check(48'(reg_sel_reg), 48'(exp[i]));
      check(48'(store_reg.lo), 48'h1000 + 48'(i));
    end
  endtask
  task automatic t_return_address_reg;
    return_address_reg <= 24'h5a1234;
    flow_context_flags <= 8'hc3;
    wr_addr <= 4'h6;
    issue(32'heb0006f5);
    check({store_reg.dbl, store_reg.hi, store_reg.lo, flush_reg},
      {1'b1, 16'hc35a, 16'h1234, 1'b1});
    for (int i = 0; i < 4; i++) begin
      check(48'(busy_reg), 48'h1);
      instr_valid <= 1'b1;
      instr <= 32'he5000098;
      @(posedge clk);
      #1;
    end
    check({busy_reg, store_reg.valid, flush_reg}, 48'h0);
    instr_valid <= 1'b0;
    check({word_even, word_odd}, 48'hc35a1234);
  endtask
  task automatic ldst(input smx_mode_t m, input logic [39:0] acc, input logic [15:0] t2,
      input logic [39:0] e_acc, input logic [15:0] e_lo);
    mode <= m;
    source_accumulator <= acc;
    shift_count_temp <= t2;
    issue(32'h870000c0);
    check({acc_wr_en_reg, acc_wr_data_reg}, {8'h01, e_acc});
    check({store_reg.valid, store_reg.lo}, {31'h1, e_lo});
  endtask
  task automatic multiply_op(input logic [31:0] op, input smx_mode_t m, input logic [39:0] src,
      input logic [39:0] dst, input logic [39:0] e_acc, input logic e_ovf);
    mode <= m;
    source_accumulator <= src;
    destination_accumulator <= dst;
    issue(op);
    check({acc_wr_en_reg, accumulator_overflow_flag_reg, acc_wr_data_reg},
      {6'h0, 1'b1, e_ovf, e_acc});
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    {instr_valid, instr, mode, cpu_reg_value, shift_count_temp, cmem_data, return_address_reg,
      flow_context_flags, source_accumulator, destination_accumulator, wr_addr} = '0;
    rst = 1'b1;
    xmem_data = 16'h8000;
    temp_reg = 16'hfffe;
    smem_data = 16'h8000;
    extended_pointer_source = 23'h7f3492;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regsel();
    t_return_address_reg();
    wr_addr <= 4'h2;
    issue(32'hed000095);
    check({store_reg.dbl, store_reg.hi, store_reg.lo}, 48'h1007f3492);
    issue(32'h00000000);
    check({store_reg.valid, acc_wr_en_reg}, 48'h0);
    ldst(8'h14, 40'h0000123400, 16'h0004, 40'hff80000000, 16'h0123);
    ldst(8'h10, 40'h0000000001, 16'h0040, 40'h0080000000, 16'h8000);
    ldst(8'h16, 40'h0012340000, 16'h002c, 40'hff80000000, 16'h0123);
    ldst(8'h11, 40'h0123450000, 16'h0000, 40'h0080000000, 16'hffff);
    ldst(8'h14, 40'h8000000000, 16'hfff0, 40'hff80000000, 16'hff80);
    multiply_op(32'h54060006, 8'h10, 40'h0260003400, 40'h00c0000000, 40'h0048000000, 1'b0);
    multiply_op(32'h54060006, 8'h08, 40'h00c0000000, 40'h00c0000000, 40'h007fffffff, 1'b1);
    multiply_op(32'h54060006, 8'hd0, 40'h0180000000, 40'h0180000000, 40'h007fffffff, 1'b0);
    multiply_op(32'h79ffc001, 8'h10, 40'h0000020000, 40'h0, 40'h0000000000, 1'b0);
    multiply_op(32'h58000000, 8'h90, 40'h0000030000, 40'h0, 40'hfffffffff4, 1'b0);
    multiply_op(32'h79ffc000, 8'h10, 40'h0000020000, 40'h0, 40'hffffffff80, 1'b0);
    multiply_op(32'hd3000000, 8'h30, 40'h0000020000, 40'h0, 40'hffffff0000, 1'b0);
    cmem_data <= 16'h0003;
    multiply_op(32'hd1000000, 8'h10, 40'h0, 40'h0, 40'hfffffe8000, 1'b0);
    wrap_up();
  end
endmodule
bind smx_exec smx_exec_sva chk_u (.clk, .rst, .instr_valid, .instr, .extended_pointer_source,
  .return_address_reg, .flow_context_flags, .cpu_reg_value, .reg_sel_reg, .store_reg,
  .acc_wr_en_reg, .accumulator_overflow_flag_reg, .flush_reg, .busy_reg);
`default_nettype wire
